/* rtl/fde_pkg.sv */
package fde_pkg;
  // Register byte offsets on the Wishbone slave
  localparam logic [4:0] OFS_HARD_STATUS = 5'h00;
  localparam logic [4:0] OFS_MEM_STATUS = 5'h04;
  localparam logic [4:0] OFS_BUS_STATUS = 5'h08;
  localparam logic [4:0] OFS_USAGE_STATUS = 5'h0C;
  localparam logic [4:0] OFS_MEM_ADDR = 5'h10;
  localparam logic [4:0] OFS_BUS_ADDR = 5'h14;
  localparam logic [4:0] OFS_PRIORITY = 5'h18;
  localparam logic [4:0] OFS_CONTROL = 5'h1C;
  // Hard fault status bits
  localparam int HS_VECTOR = 0;
  localparam int HS_ESCALATED = 1;
  // Memory-management status bits
  localparam int MS_INSTR = 0;
  localparam int MS_DATA = 1;
  localparam int MS_UNSTACK = 2;
  localparam int MS_STACK = 3;
  localparam int MS_ADDR_VALID = 4;
  // Bus status bits
  localparam int BS_INSTR = 0;
  localparam int BS_PRECISE = 1;
  localparam int BS_INEXACT = 2;
  localparam int BS_UNSTACK = 3;
  localparam int BS_STACK = 4;
  localparam int BS_ADDR_VALID = 5;
  // Usage status bits
  localparam int US_UNDEFINED_INSTR_FLAG = 0;
  localparam int US_INVSTATE = 1;
  localparam int US_INVRET = 2;
  localparam int US_NO_COPROCESSOR_FLAG = 3;
  localparam int US_UNALIGNED_ACCESS_FLAG = 4;
  localparam int US_DIVIDE_ZERO_FLAG = 5;
  // Control register bits: handler enables for the configurable classes
  localparam int CT_MEM_EN = 0;
  localparam int CT_BUS_EN = 1;
  localparam int CT_USAGE_EN = 2;
  // Priority register fields, 8 bits per class
  localparam int PRI_W = 8;
  localparam int PRI_MEM_LSB = 0;
  localparam int PRI_BUS_LSB = 8;
  localparam int PRI_USAGE_LSB = 16;
  localparam logic [PRI_W-1:0] PRI_RESET = 8'h00;
  // Exception return pattern: upper 28 bits all ones
  localparam logic [27:0] RET_UPPER = 28'hFFFFFFF;
  localparam logic [3:0] RET_HANDLER_MAIN = 4'h1;
  localparam logic [3:0] RET_THREAD_MAIN = 4'h9;
  localparam logic [3:0] RET_THREAD_PROC = 4'hD;
  // Fault classes reported to the pipeline
  typedef enum logic [2:0] {
    FDE_NONE, FDE_HARD, FDE_MEM, FDE_BUS, FDE_USAGE
  } fde_class_t;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;
endpackage : fde_pkg

/* rtl/fde_evt_if.sv */
`timescale 1ns/1ns
`default_nettype none
// Classified fault events passed from the classifier to the core
interface fde_evt_if;
  logic [4:0] mem_set;
  logic [5:0] bus_set;
  logic [5:0] usage_set;
  logic vector_err;
  logic mem_any;
  logic bus_any;
  logic usage_any;
  modport src (output mem_set, bus_set, usage_set, vector_err, mem_any, bus_any, usage_any);
  modport dst (input mem_set, bus_set, usage_set, vector_err, mem_any, bus_any, usage_any);
endinterface : fde_evt_if
`default_nettype wire

/* rtl/fde_classify.sv */
`timescale 1ns/1ns
`default_nettype none
// Purely combinational sorting of raw fault sources into per-class flags
module fde_classify (
  input wire logic ifetch_mpu_viol_i,  // Instruction access denied by protection unit
  input wire logic ifetch_xn_i,        // Instruction fetched from non-executable region
  input wire logic ifetch_bus_err_i,   // Bus error on prefetch
  input wire logic vec_bus_err_i,      // Bus error on vector read
  input wire logic data_mpu_viol_i,    // Data access denied
  input wire logic data_bus_err_i,     // Precise data bus error
  input wire logic data_bus_inexact_i, // Imprecise data bus error
  input wire logic stack_mpu_viol_i,   // Protection violation while stacking
  input wire logic unstack_mpu_viol_i, // Protection violation while unstacking
  input wire logic stack_bus_err_i,    // Bus error while stacking
  input wire logic unstack_bus_err_i,  // Bus error while unstacking
  input wire logic no_coprocessor_flag_i,             // Coprocessor access
  input wire logic undefined_instr_flag_i,            // Undefined instruction
  input wire logic bad_isa_i,          // Attempt to leave the native instruction set
  input wire logic cont_bad_target_i,  // Continuation state on non load/store-multiple
  input wire logic exc_ret_i,          // Exception return attempted
  input wire logic [31:0] exc_ret_code_i, // Returned code
  input wire logic unaligned_access_flag_i,          // Illegal unaligned access
  input wire logic divide_zero_flag_i,             // Divide by zero
  fde_evt_if.src evt                   // Classified events
);
  // Only three codes with all-ones upper bits are legal returns
  function automatic logic ret_valid(input logic [31:0] c);
    ret_valid = (c[31:4] == fde_pkg::RET_UPPER) &&
                (c[3:0] == fde_pkg::RET_HANDLER_MAIN || c[3:0] == fde_pkg::RET_THREAD_MAIN ||
                 c[3:0] == fde_pkg::RET_THREAD_PROC);
  endfunction : ret_valid

  // Non-executable fetch faults whether or not the protection unit is on
  always_comb begin
    evt.mem_set = '0;
    evt.mem_set[fde_pkg::MS_INSTR] = ifetch_mpu_viol_i | ifetch_xn_i;
    evt.mem_set[fde_pkg::MS_DATA] = data_mpu_viol_i;
    evt.mem_set[fde_pkg::MS_STACK] = stack_mpu_viol_i;
    evt.mem_set[fde_pkg::MS_UNSTACK] = unstack_mpu_viol_i;
    evt.mem_set[fde_pkg::MS_ADDR_VALID] = data_mpu_viol_i;
  end

  // Bus class
  always_comb begin
    evt.bus_set = '0;
    evt.bus_set[fde_pkg::BS_STACK] = stack_bus_err_i;
    evt.bus_set[fde_pkg::BS_UNSTACK] = unstack_bus_err_i;
    evt.bus_set[fde_pkg::BS_INSTR] = ifetch_bus_err_i;
    evt.bus_set[fde_pkg::BS_PRECISE] = data_bus_err_i;
    evt.bus_set[fde_pkg::BS_INEXACT] = data_bus_inexact_i;
    evt.bus_set[fde_pkg::BS_ADDR_VALID] = data_bus_err_i;
  end

  // Usage class
  always_comb begin
    evt.usage_set = '0;
    evt.usage_set[fde_pkg::US_NO_COPROCESSOR_FLAG] = no_coprocessor_flag_i;
    evt.usage_set[fde_pkg::US_UNDEFINED_INSTR_FLAG] = undefined_instr_flag_i;
    evt.usage_set[fde_pkg::US_INVSTATE] = bad_isa_i | cont_bad_target_i;
    evt.usage_set[fde_pkg::US_INVRET] = exc_ret_i & ~ret_valid(exc_ret_code_i);
    evt.usage_set[fde_pkg::US_UNALIGNED_ACCESS_FLAG] = unaligned_access_flag_i;
    evt.usage_set[fde_pkg::US_DIVIDE_ZERO_FLAG] = divide_zero_flag_i;
  end

  assign evt.vector_err = vec_bus_err_i;
  assign evt.mem_any = |evt.mem_set;
  assign evt.bus_any = |evt.bus_set;
  assign evt.usage_any = |evt.usage_set;
endmodule : fde_classify
`default_nettype wire

/* rtl/fde_wb_regs.sv */
`timescale 1ns/1ns
`default_nettype none
// Classic Wishbone slave: registered ack, read data from flops, write on the ack edge
module fde_wb_regs (
  input wire logic clk_i,             // Core clock
  input wire logic rst_i,             // Synchronous reset
  input wire logic wb_cyc_i,          // Cycle
  input wire logic wb_stb_i,          // Strobe
  input wire logic wb_we_i,           // Write enable
  input wire logic [4:0] wb_adr_i,    // Byte address
  input wire logic [3:0] wb_sel_i,    // Byte selects
  input wire logic [31:0] wb_dat_i,   // Write data
  input wire logic [255:0] rd_bus_i,  // Eight read words, word 0 lowest
  output logic [31:0] wb_dat_o,       // Read data
  output logic wb_ack_o,              // Acknowledge
  output logic wr_stb_o,              // Write accepted this cycle
  output logic [2:0] wr_idx_o,        // Word index written
  output logic [31:0] wr_mask_o       // Byte-lane bit mask
);
  logic req;
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // Ack one cycle after the request; drops the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // Read data latched with the ack; unmapped offsets cannot exist in a 3-bit index
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= fde_pkg::ZERO_WORD;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= rd_bus_i[wb_adr_i[4:2]*32 +: 32];
    end
  end

  // Write lands on the edge at which the master sees ack, while its request still stands
  assign wr_stb_o = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
  assign wr_idx_o = wb_adr_i[4:2];
  genvar g;
  for (g = 0; g < 4; g++) begin : g_lane
    assign wr_mask_o[g*8 +: 8] = {8{wb_sel_i[g]}};
  end
endmodule : fde_wb_regs
`default_nettype wire

/* rtl/fde_fault_unit.sv */
// Our own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module fde_fault_unit (
  input wire logic clk_i,               // Core clock, 10 MHz
  input wire logic rst_i,               // Synchronous reset, active high
  // Wishbone slave
  input wire logic wb_cyc_i,            // Cycle
  input wire logic wb_stb_i,            // Strobe
  input wire logic wb_we_i,             // Write enable
  input wire logic [4:0] wb_adr_i,      // Byte address
  input wire logic [3:0] wb_sel_i,      // Byte selects
  input wire logic [31:0] wb_dat_i,     // Write data
  output logic [31:0] wb_dat_o,         // Read data
  output logic wb_ack_o,                // Acknowledge
  // Fault sources from pipeline, bus interface and protection unit
  input wire logic ifetch_mpu_viol_i,   // Instruction access denied
  input wire logic ifetch_xn_i,         // Fetch from non-executable region
  input wire logic ifetch_bus_err_i,    // Prefetch bus error
  input wire logic vec_bus_err_i,       // Vector read bus error
  input wire logic data_mpu_viol_i,     // Data access denied
  input wire logic data_bus_err_i,      // Precise data bus error
  input wire logic data_bus_inexact_i,  // Imprecise data bus error
  input wire logic stack_mpu_viol_i,    // Violation while stacking
  input wire logic unstack_mpu_viol_i,  // Violation while unstacking
  input wire logic stack_bus_err_i,     // Bus error while stacking
  input wire logic unstack_bus_err_i,   // Bus error while unstacking
  input wire logic no_coprocessor_flag_i,              // Coprocessor access
  input wire logic undefined_instr_flag_i,             // Undefined instruction
  input wire logic bad_isa_i,           // Foreign instruction set
  input wire logic cont_bad_target_i,   // Bad continuation target
  input wire logic exc_ret_i,           // Exception return attempt
  input wire logic [31:0] exc_ret_code_i, // Returned code
  input wire logic unaligned_access_flag_i,           // Illegal unaligned access
  input wire logic divide_zero_flag_i,              // Divide by zero
  input wire logic [31:0] fault_addr_i, // Address of the faulting data access
  // Execution context
  input wire logic in_handler_i,        // Some exception handler is running
  input wire logic [7:0] cur_pri_i,     // Current execution priority, lower is more urgent
  input wire fde_pkg::fde_class_t active_class_i, // Class of running fault handler
  input wire logic in_nmi_i,            // NMI handler running
  input wire logic in_hard_i,           // Hard fault handler running
  input wire logic stacking_bus_entry_i,// Stacking on entry to bus fault handler
  input wire logic nmi_i,               // NMI request pulse
  input wire logic debug_halt_i,        // Debugger halt pulse
  // Results
  output fde_pkg::fde_class_t fault_take_o, // Exception to take this cycle
  output logic lockup_o                 // Processor locked up, no execution
);
  fde_evt_if evt ();

  fde_classify u_classify (
    .ifetch_mpu_viol_i(ifetch_mpu_viol_i),
    .ifetch_xn_i(ifetch_xn_i),
    .ifetch_bus_err_i(ifetch_bus_err_i),
    .vec_bus_err_i(vec_bus_err_i),
    .data_mpu_viol_i(data_mpu_viol_i),
    .data_bus_err_i(data_bus_err_i),
    .data_bus_inexact_i(data_bus_inexact_i),
    .stack_mpu_viol_i(stack_mpu_viol_i),
    .unstack_mpu_viol_i(unstack_mpu_viol_i),
    .stack_bus_err_i(stack_bus_err_i),
    .unstack_bus_err_i(unstack_bus_err_i),
    .no_coprocessor_flag_i(no_coprocessor_flag_i),
    .undefined_instr_flag_i(undefined_instr_flag_i),
    .bad_isa_i(bad_isa_i),
    .cont_bad_target_i(cont_bad_target_i),
    .exc_ret_i(exc_ret_i),
    .exc_ret_code_i(exc_ret_code_i),
    .unaligned_access_flag_i(unaligned_access_flag_i),
    .divide_zero_flag_i(divide_zero_flag_i),
    .evt(evt)
  );

  logic [1:0] hard_fault_status_reg;
  logic [4:0] mem_manage_fault_status_reg;
  logic [5:0] bus_fault_status_reg;
  logic [5:0] usage_fault_status_reg;
  logic [31:0] mem_manage_fault_address_reg;
  logic [31:0] bus_fault_address_reg;
  logic [23:0] system_handler_priority_reg;
  logic [2:0] system_handler_control_reg;
  logic lockup_reg;
  logic lock_from_nmi_reg;
  logic [255:0] rd_bus;
  logic wr_stb;
  logic [2:0] wr_idx;
  logic [31:0] wr_mask;

  fde_wb_regs u_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .rd_bus_i(rd_bus),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .wr_stb_o(wr_stb),
    .wr_idx_o(wr_idx),
    .wr_mask_o(wr_mask)
  );

  // Write-one-to-clear mask per status word
  function automatic logic [31:0] w1c(input logic [2:0] idx, input logic [4:0] ofs,
                                      input logic stb, input logic [2:0] widx,
                                      input logic [31:0] m, input logic [31:0] d);
    w1c = (stb && widx == ofs[4:2]) ? (m & d) : fde_pkg::ZERO_WORD;
  endfunction : w1c

  logic [31:0] clr_hard, clr_mem, clr_bus, clr_usage;
  assign clr_hard = w1c(wr_idx, fde_pkg::OFS_HARD_STATUS, wr_stb, wr_idx, wr_mask, wb_dat_i);
  assign clr_mem = w1c(wr_idx, fde_pkg::OFS_MEM_STATUS, wr_stb, wr_idx, wr_mask, wb_dat_i);
  assign clr_bus = w1c(wr_idx, fde_pkg::OFS_BUS_STATUS, wr_stb, wr_idx, wr_mask, wb_dat_i);
  assign clr_usage = w1c(wr_idx, fde_pkg::OFS_USAGE_STATUS, wr_stb, wr_idx, wr_mask, wb_dat_i);

  // Priority fields, lower value is more urgent
  logic [7:0] pri_mem, pri_bus, pri_usage;
  assign pri_mem = system_handler_priority_reg[fde_pkg::PRI_MEM_LSB +: fde_pkg::PRI_W];
  assign pri_bus = system_handler_priority_reg[fde_pkg::PRI_BUS_LSB +: fde_pkg::PRI_W];
  assign pri_usage = system_handler_priority_reg[fde_pkg::PRI_USAGE_LSB +: fde_pkg::PRI_W];

  // Decide whether a configurable fault must escalate
  function automatic logic must_escalate(input fde_pkg::fde_class_t cls, input logic [7:0] pri,
                                         input logic en, input fde_pkg::fde_class_t act,
                                         input logic busy, input logic [7:0] cur);
    must_escalate = !en ||
                    (act == cls) ||
                    (busy && pri >= cur);
  endfunction : must_escalate

  logic esc_mem, esc_bus, esc_usage, esc_any, hard_now, bus_stack_exempt;
  // Stacking failure into the bus handler itself still runs the bus handler
  assign bus_stack_exempt = stacking_bus_entry_i & evt.bus_set[fde_pkg::BS_STACK];
  assign esc_mem = evt.mem_any &
    must_escalate(fde_pkg::FDE_MEM, pri_mem, system_handler_control_reg[fde_pkg::CT_MEM_EN],
                  active_class_i, in_handler_i, cur_pri_i);
  assign esc_bus = evt.bus_any & ~bus_stack_exempt &
    must_escalate(fde_pkg::FDE_BUS, pri_bus, system_handler_control_reg[fde_pkg::CT_BUS_EN],
                  active_class_i, in_handler_i, cur_pri_i);
  assign esc_usage = evt.usage_any &
    must_escalate(fde_pkg::FDE_USAGE, pri_usage, system_handler_control_reg[fde_pkg::CT_USAGE_EN],
                  active_class_i, in_handler_i, cur_pri_i);
  assign esc_any = esc_mem | esc_bus | esc_usage;
  assign hard_now = evt.vector_err | esc_any;

  // Exception selection; hard fault outranks every configurable class
  always_comb begin
    fault_take_o = fde_pkg::FDE_NONE;
    if (lockup_reg) begin
      fault_take_o = fde_pkg::FDE_NONE;
    end else if (hard_now) begin
      // A hard fault never preempts a running hard fault or NMI handler
      fault_take_o = (in_hard_i || in_nmi_i) ? fde_pkg::FDE_NONE : fde_pkg::FDE_HARD;
    end else if (evt.mem_any) begin
      fault_take_o = fde_pkg::FDE_MEM;
    end else if (evt.bus_any) begin
      fault_take_o = fde_pkg::FDE_BUS;
    end else if (evt.usage_any) begin
      fault_take_o = fde_pkg::FDE_USAGE;
    end
  end

  // Hard fault status; a set in the clear cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hard_fault_status_reg <= '0;
    end else begin
      hard_fault_status_reg <= (hard_fault_status_reg & ~clr_hard[1:0]) |
                               {esc_any, evt.vector_err};
    end
  end

  // Configurable class status words, sticky until written with ones
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_manage_fault_status_reg <= '0;
      bus_fault_status_reg <= '0;
      usage_fault_status_reg <= '0;
    end else begin
      mem_manage_fault_status_reg <= (mem_manage_fault_status_reg & ~clr_mem[4:0]) | evt.mem_set;
      bus_fault_status_reg <= (bus_fault_status_reg & ~clr_bus[5:0]) | evt.bus_set;
      usage_fault_status_reg <= (usage_fault_status_reg & ~clr_usage[5:0]) | evt.usage_set;
    end
  end

  // Address capture; kept while its valid bit is set so the first fault is not overwritten
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_manage_fault_address_reg <= fde_pkg::ZERO_WORD;
      bus_fault_address_reg <= fde_pkg::ZERO_WORD;
    end else begin
      // A clear of the valid bit in the same cycle frees the register for the new address
      if (evt.mem_set[fde_pkg::MS_ADDR_VALID] &&
          !(mem_manage_fault_status_reg[fde_pkg::MS_ADDR_VALID] & ~clr_mem[fde_pkg::MS_ADDR_VALID])) begin
        mem_manage_fault_address_reg <= fault_addr_i;
      end
      if (evt.bus_set[fde_pkg::BS_ADDR_VALID] &&
          !(bus_fault_status_reg[fde_pkg::BS_ADDR_VALID] & ~clr_bus[fde_pkg::BS_ADDR_VALID])) begin
        bus_fault_address_reg <= fault_addr_i;
      end
    end
  end

  // Priority and enable registers, byte-lane writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      system_handler_priority_reg <= {3{fde_pkg::PRI_RESET}};
      system_handler_control_reg <= '0;
    end else if (wr_stb) begin
      if (wr_idx == fde_pkg::OFS_PRIORITY[4:2]) begin
        system_handler_priority_reg <= (system_handler_priority_reg & ~wr_mask[23:0]) |
                                       (wb_dat_i[23:0] & wr_mask[23:0]);
      end
      if (wr_idx == fde_pkg::OFS_CONTROL[4:2] && wr_mask[0]) begin
        system_handler_control_reg <= wb_dat_i[2:0];
      end
    end
  end

  // Lockup: hard fault while in NMI or hard fault handler stops execution
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lockup_reg <= 1'b0;
      lock_from_nmi_reg <= 1'b0;
    end else if (!lockup_reg) begin
      if (hard_now && (in_nmi_i || in_hard_i)) begin
        lockup_reg <= 1'b1;
        lock_from_nmi_reg <= in_nmi_i;
      end
    end else if (debug_halt_i || (nmi_i && !lock_from_nmi_reg)) begin
      lockup_reg <= 1'b0;
      lock_from_nmi_reg <= 1'b0;
    end
  end
  assign lockup_o = lockup_reg;

  // Read map, word index order
  always_comb begin
    rd_bus = '0;
    rd_bus[fde_pkg::OFS_HARD_STATUS[4:2]*32 +: 32] = {30'h00000000, hard_fault_status_reg};
    rd_bus[fde_pkg::OFS_MEM_STATUS[4:2]*32 +: 32] = {27'h0000000, mem_manage_fault_status_reg};
    rd_bus[fde_pkg::OFS_BUS_STATUS[4:2]*32 +: 32] = {26'h0000000, bus_fault_status_reg};
    rd_bus[fde_pkg::OFS_USAGE_STATUS[4:2]*32 +: 32] = {26'h0000000, usage_fault_status_reg};
    rd_bus[fde_pkg::OFS_MEM_ADDR[4:2]*32 +: 32] = mem_manage_fault_address_reg;
    rd_bus[fde_pkg::OFS_BUS_ADDR[4:2]*32 +: 32] = bus_fault_address_reg;
    rd_bus[fde_pkg::OFS_PRIORITY[4:2]*32 +: 32] = {8'h00, system_handler_priority_reg};
    rd_bus[fde_pkg::OFS_CONTROL[4:2]*32 +: 32] = {28'h0000000, lockup_reg, system_handler_control_reg};
  end
endmodule : fde_fault_unit
`default_nettype wire

/* verif/fde_fault_unit_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
// Pin-level checks on the fault unit
module fde_fault_unit_assertions (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_ack_o, // Ack
  input wire logic vec_bus_err_i, // Vector error
  input wire logic stack_bus_err_i, // Stacking error
  input wire logic stacking_bus_entry_i, // Bus handler entry
  input wire logic in_nmi_i, // In NMI
  input wire logic in_hard_i, // In hard fault
  input wire logic nmi_i, // NMI pulse
  input wire logic debug_halt_i, // Halt pulse
  input wire fde_pkg::fde_class_t fault_take_o, // Class taken
  input wire logic lockup_o // Lockup
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A fresh request, not the idle cycle after an answer
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  ack_latency_a: assert property (req_s |=> wb_ack_o)
    else $error("ack late");
  lock_entry_a: assert property (vec_bus_err_i && (in_nmi_i || in_hard_i) && !nmi_i && !debug_halt_i
    |=> lockup_o)
    else $error("no lockup");
  lock_hold_a: assert property (lockup_o && !nmi_i && !debug_halt_i |=> lockup_o)
    else $error("lockup left");
  locked_quiet_a: assert property (lockup_o |-> fault_take_o == fde_pkg::FDE_NONE)
    else $error("fault taken while locked");
  vec_hard_a: assert property (vec_bus_err_i && !in_nmi_i && !in_hard_i && !lockup_o
    |-> fault_take_o == fde_pkg::FDE_HARD)
    else $error("vector error not hard");
  hard_nested_a: assert property (in_nmi_i || in_hard_i |-> fault_take_o != fde_pkg::FDE_HARD)
    else $error("hard fault nested");
  stack_keep_a: assert property (stacking_bus_entry_i && stack_bus_err_i && !vec_bus_err_i && !in_nmi_i
    && !in_hard_i && !lockup_o |-> fault_take_o == fde_pkg::FDE_BUS)
    else $error("stacking fault escalated");
  nmi_lock_a: assert property (lockup_o && in_nmi_i && nmi_i && !debug_halt_i |=> lockup_o)
    else $error("NMI freed lockup");
endmodule : fde_fault_unit_assertions
`default_nettype wire

/* verif/fde_core_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Pipeline, bus unit and protection unit raising one-cycle fault pulses
module fde_core_model (
  input wire logic clk_i, // Clock
  output logic [17:0] flt_o = 18'h00000, // One bit per fault source
  output logic [31:0] addr_o = 32'h20000040, // Faulting data address
  output logic [31:0] ret_o = 32'hFFFFFFF0 // Return code, reserved at first
);
  // Raise source k; returns mid-cycle so the caller sees the answer
  task fire(input int k);
    @(posedge clk_i);
    flt_o <= 18'h00001 << k;
    @(negedge clk_i);
  endtask : fire
  // Pulses last one cycle only
  task quiet;
    @(posedge clk_i);
    flt_o <= 18'h00000;
  endtask : quiet
  task ret(input logic [31:0] c);
    @(posedge clk_i);
    ret_o <= c;
  endtask : ret
endmodule : fde_core_model
`default_nettype wire

/* verif/test_fde_fault_unit.sv */
`timescale 1ns/1ns
`default_nettype none
module test_fde_fault_unit;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, ih = 1'b0, nm = 1'b0, hd = 1'b0, sb = 1'b0;
  logic nmi = 1'b0, dh = 1'b0, ack, lk;
  logic [4:0] adr = 5'h00;
  logic [7:0] pri = 8'h00;
  logic [17:0] f;
  logic [31:0] dat = 32'h00000000, rd, wdo, fa, rc;
  fde_pkg::fde_class_t act = fde_pkg::FDE_NONE, ft;
  int miscompares = 0, n_compared = 0, cyc_n = 0;
  // Per source: class taken, status word index, status bit
  localparam int CL[18] = '{2, 2, 3, 1, 2, 3, 3, 2, 2, 3, 3, 4, 4, 4, 4, 4, 4, 4};
  localparam int OF[18] = '{1, 1, 2, 0, 1, 2, 2, 1, 1, 2, 2, 3, 3, 3, 3, 3, 3, 3};
  localparam int BT[18] = '{0, 0, 0, 0, 1, 1, 2, 3, 2, 4, 3, 3, 0, 1, 1, 2, 4, 5};
  initial forever #50 clk_i = ~clk_i;
  fde_core_model i_m (.clk_i, .flt_o(f), .addr_o(fa), .ret_o(rc));
  fde_fault_unit i_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wdo), .wb_ack_o(ack), .ifetch_mpu_viol_i(f[0]), .ifetch_xn_i(f[1]),
    .ifetch_bus_err_i(f[2]), .vec_bus_err_i(f[3]), .data_mpu_viol_i(f[4]), .data_bus_err_i(f[5]),
    .data_bus_inexact_i(f[6]), .stack_mpu_viol_i(f[7]), .unstack_mpu_viol_i(f[8]), .stack_bus_err_i(f[9]),
    .unstack_bus_err_i(f[10]), .no_coprocessor_flag_i(f[11]), .undefined_instr_flag_i(f[12]), .bad_isa_i(f[13]), .cont_bad_target_i(f[14]),
    .exc_ret_i(f[15]), .exc_ret_code_i(rc), .unaligned_access_flag_i(f[16]), .divide_zero_flag_i(f[17]), .fault_addr_i(fa),
    .in_handler_i(ih), .cur_pri_i(pri), .active_class_i(act), .in_nmi_i(nm), .in_hard_i(hd),
    .stacking_bus_entry_i(sb), .nmi_i(nmi), .debug_halt_i(dh), .fault_take_o(ft), .lockup_o(lk));
  task check(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value at %0t: saw %h, want %h", $time, s, e);
    end
  endtask : check
  // Classic single cycle; read data taken at the ack edge
  task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rd = wdo;
    cyc <= 1'b0;
  endtask : wb
  task shot(input int k, input int e);
    i_m.fire(k);
    check(ft, e);
    i_m.quiet();
  endtask : shot
  // Release pulse: NMI or debugger halt
  task rel(input logic n);
    @(posedge clk_i);
    if (n) nmi <= 1'b1; else dh <= 1'b1;
    @(posedge clk_i);
    nmi <= 1'b0;
    dh <= 1'b0;
    @(negedge clk_i);
  endtask : rel
  task t_disabled;
    wb(0, 5'h1C, 32'h0);
    check(rd, 32'h0);
    shot(12, 1);
    wb(0, 5'h00, 32'h0);
    check(rd[1], 1'b1);
    wb(1, 5'h00, 32'hFFFFFFFF);
    wb(0, 5'h00, 32'h0);
    check(rd, 32'h0);
  endtask : t_disabled
  task t_causes;
    wb(1, 5'h1C, 32'h7);
    for (int k = 0; k < 18; k++) begin
      for (int j = 0; j < 4; j++) wb(1, 5'(j * 4), 32'hFFFFFFFF);
      shot(k, CL[k]);
      wb(0, 5'(OF[k] * 4), 32'h0);
      check(rd[BT[k]], 1'b1);
      if (k == 4 || k == 5) wb(0, (k == 4) ? 5'h10 : 5'h14, 32'h0);
      if (k == 4 || k == 5) check(rd, 32'h20000040);
    end
    // Each of the three legal return codes must pass without a usage flag
    wb(1, 5'h0C, 32'hFFFFFFFF);
    for (int k = 0; k < 3; k++) begin
      i_m.ret({28'hFFFFFFF, (k == 0) ? 4'h1 : (k == 1) ? 4'h9 : 4'hD});
      shot(15, 0);
    end
    wb(0, 5'h0C, 32'h0);
    check(rd, 32'h0);
  endtask : t_causes
  task t_escalate;
    wb(1, 5'h18, 32'h00404040);
    wb(0, 5'h18, 32'h0);
    check(rd, 32'h00404040);
    ih <= 1'b1;
    pri <= 8'h40;
    shot(12, 1);
    pri <= 8'h41;
    shot(12, 4);
    act <= fde_pkg::FDE_USAGE;
    pri <= 8'hFF;
    shot(12, 1);
    act <= fde_pkg::FDE_BUS;
    sb <= 1'b1;
    pri <= 8'h00;
    shot(9, 3);
    sb <= 1'b0;
  endtask : t_escalate
  task t_lockup;
    hd <= 1'b1;
    shot(3, 0);
    @(negedge clk_i);
    check(lk, 1'b1);
    // Lockup shows in the control word next to the three enables
    wb(0, 5'h1C, 32'h0);
    check(rd, 32'h0000000F);
    rel(1);
    check(lk, 1'b0);
    @(posedge clk_i);
    hd <= 1'b0;
    nm <= 1'b1;
    shot(3, 0);
    rel(1);
    check(lk, 1'b1);
    rel(0);
    check(lk, 1'b0);
  endtask : t_lockup
  task end_sim;
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // Hang guard, far beyond the few hundred cycles needed
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_disabled();
    t_causes();
    t_escalate();
    t_lockup();
    end_sim();
  end
endmodule : test_fde_fault_unit
bind fde_fault_unit fde_fault_unit_assertions i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .vec_bus_err_i, .stack_bus_err_i, .stacking_bus_entry_i, .in_nmi_i, .in_hard_i, .nmi_i, .debug_halt_i,
  .fault_take_o, .lockup_o);
`default_nettype wire
